// [css_pkg.sv]
// Package with constants and types of the command source selector.
// Notes on behaviour
// - Start source 0 communication, 1 terminals.
// - Speed source picks frequency command path.
// - Network source 0 option, 2 panel link.
// - Network 9999: panel link unless option fitted.
// - Local source 2 connector, 3 USB, 4 panel.
// - Local 9999: USB, then handheld, then panel.
// - Local 9999 never auto-picks serial link.
// - Both 2: local wins, network needs option.
// - Option routed but absent: refuse network.
// - Modbus-RTU refused in local unit mode.
// - New settings apply only after reset.
// - Network and local settings always writable.
// - Start/speed writable at group 0 or option.
// - Reads and monitoring always served.
// - Operation mode setting 1, 3 or 4 fixes the mode; 1 boots into local unit mode.
`default_nettype none
package css_pkg;
   // -----------------------------------------------------------------
   // Setting codes.
   // -----------------------------------------------------------------
   localparam logic [13:0] CSS_AUTO      = 14'h270F; // Automatic selection value.
   localparam logic [13:0] CSS_SRC_OPT   = 14'h0000; // Option card source.
   localparam logic [13:0] CSS_SRC_PANEL = 14'h0002; // Panel connector source.
   localparam logic [13:0] CSS_SRC_USB   = 14'h0003; // USB connector source.
   localparam logic [13:0] CSS_SRC_OPNL  = 14'h0004; // Operation panel source.
   localparam logic [1:0]  CSS_SPD_COMM  = 2'h0;     // Frequency from communication.
   localparam logic [1:0]  CSS_SPD_ANA   = 2'h1;     // Frequency from analog terminal.
   localparam logic [1:0]  CSS_SPD_MIX   = 2'h2;     // Communication frequency; start source unaffected.
   localparam logic [3:0]  CSS_OPM_PU    = 4'h1;     // Operation mode fixed to local unit.
   localparam logic [3:0]  CSS_OPM_COMB3 = 4'h3;     // Combined mode 1.
   localparam logic [3:0]  CSS_OPM_COMB4 = 4'h4;     // Combined mode 2.
   localparam logic [7:0]  CSS_GROUP_ALL = 8'h00;    // User group value that opens all writes.
   // -----------------------------------------------------------------
   // Interface indices, one bit each in an interface vector.
   // -----------------------------------------------------------------
   localparam int CSS_IF_OPNL  = 0;  // Operation panel.
   localparam int CSS_IF_USB   = 1;  // USB connector.
   localparam int CSS_IF_UNIT  = 2;  // Handheld unit on panel connector.
   localparam int CSS_IF_SER   = 3;  // Serial link on panel connector.
   localparam int CSS_IF_OPT   = 4;  // Option card.
   localparam int CSS_IF_N     = 5;  // Number of interfaces.
   // Operation mode of the drive.
   typedef enum logic [2:0]
   {
      CSS_MODE_EXT = 3'b001,
      CSS_MODE_PU  = 3'b010,
      CSS_MODE_NET = 3'b100
   } css_mode_t;
   // Settings bundle held in the shadow and active copies.
   typedef struct packed
   {
      logic        start_source_select;   // Start source.
      logic [1:0]  speed_source_select;   // Speed source.
      logic [13:0] network_source_select; // Network source.
      logic [13:0] local_source_select;   // Local source.
      logic [3:0]  operation_mode_select; // Operation mode setting.
   } css_cfg_t;
   // Requests offered by all interfaces, one bit per interface in each strobe vector.
   typedef struct packed
   {
      logic [CSS_IF_N-1:0] wr;     // Parameter write strobe per interface.
      logic [CSS_IF_N-1:0] run;    // Start command strobe per interface.
      logic [CSS_IF_N-1:0] freq;   // Frequency command strobe per interface.
      logic [CSS_IF_N-1:0] rd;     // Read or monitor strobe per interface.
   } css_req_t;
endpackage
`default_nettype wire

// [css_cfg_reg.sv]
// Setting register with write gate and reset-time activation.
`timescale 1ns/1ps
`default_nettype none
module css_cfg_reg #(
   parameter int          W   = 1,      // Width of the setting.
   parameter logic [W-1:0] INIT = '0     // Initial value.
)(
   input  wire logic         clk_i,      // System clock.
   input  wire logic         arst_n_i,   // Asynchronous reset, active low.
   input  wire logic         load_i,     // Copies the stored value into the active one.
   input  wire logic         we_i,       // Gated write strobe.
   input  wire logic [W-1:0] wdata_i,    // Write data.
   output logic      [W-1:0] stored_o,   // Value stored at once.
   output logic      [W-1:0] active_o    // Value used for routing.
);
   logic [W-1:0] stored_q = INIT;   // Stored copy; powers up at its initial value.
   // The stored copy takes writes at once and is not cleared by reset.
   // Clearing it would lose a new setting in the very reset that must activate it.
   always_ff @(posedge clk_i)
   begin
      if (we_i)
         stored_q <= wdata_i;
   end
   assign stored_o = stored_q;
   // The active copy is set to INIT by reset and otherwise changes only on the load pulse after reset.
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         active_o <= INIT;
      else if (load_i)
         active_o <= stored_q;
   end
endmodule
`default_nettype wire

// [css_top.sv]
// Top of the command source selector.
`timescale 1ns/1ps
`default_nettype none
module css_top (
   input  wire logic                  CLK_SYS_I,       // System clock, 200 MHz.
   input  wire logic                  ARST_N_I,        // Asynchronous reset, active low.
   input  wire logic                  OPT_FITTED_I,    // Option card present, pin.
   input  wire logic                  USB_CONN_I,      // USB host connected, pin.
   input  wire logic                  UNIT_CONN_I,     // Handheld unit connected, pin.
   input  wire logic [7:0]            USER_GROUP_I,    // User group selection value.
   input  wire logic [2:0]            SET_WE_I,        // Write: 0 start/speed, 1 network, 2 local.
   input  wire logic                  SET_OPM_WE_I,    // Write of operation mode setting.
   input  wire css_pkg::css_cfg_t     SET_DATA_I,      // Write data of all settings.
   input  wire logic                  NET_REQ_I,       // Request to enter network mode, pulse.
   input  wire logic                  PU_REQ_I,        // Request to enter local unit mode, pulse.
   input  wire logic                  EXT_REQ_I,       // Request to enter external mode, pulse.
   input  wire logic                  MODBUS_I,        // Serial link uses Modbus-RTU.
   input  wire css_pkg::css_req_t     REQ_I,           // Requests from the interfaces.
   output logic [2:0]                 MODE_O,          // Current operation mode, one-hot.
   output logic [4:0]                 AUTH_O,          // Interface holding command authority.
   output logic                       START_TERM_O,    // Start taken from terminals.
   output logic                       FREQ_ANALOG_O,   // Frequency taken from analog terminal.
   output logic                       FREQ_COMM_O,     // Communication frequency valid.
   output logic                       MODE_REFUSED_O,  // Network mode entry refused, pulse.
   output css_pkg::css_req_t          GRANT_O,         // Requests accepted, pulses.
   output css_pkg::css_req_t          REJECT_O,        // Requests rejected, pulses.
   output css_pkg::css_cfg_t          STORED_O         // Stored settings.
);
   import css_pkg::*;
   // ---------------------------------------------------------------
   // Pin synchronisers.
   // ---------------------------------------------------------------
   logic [2:0] pin_s1_q;   // First stage, read only by second stage.
   logic [2:0] pin_s2_q;   // Second stage, usable.
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         pin_s1_q <= 3'h0;
         pin_s2_q <= 3'h0;
      end
      else
      begin
         pin_s1_q <= {UNIT_CONN_I, USB_CONN_I, OPT_FITTED_I};
         pin_s2_q <= pin_s1_q;
      end
   end
   logic opt_s;   // Option card fitted.
   logic usb_s;   // USB connected.
   logic unit_s;  // Handheld unit connected.
   assign opt_s  = pin_s2_q[0];
   assign usb_s  = pin_s2_q[1];
   assign unit_s = pin_s2_q[2];
   // ---------------------------------------------------------------
   // Reset release pulse that activates settings.
   // ---------------------------------------------------------------
   logic load_q;   // High during the cycles before release is seen.
   logic boot_q;   // One-cycle pulse after reset.
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         load_q <= 1'b1;
         boot_q <= 1'b0;
      end
      else
      begin
         load_q <= 1'b0;
         boot_q <= load_q;
      end
   end
   // ---------------------------------------------------------------
   // Settings with write gates.
   // ---------------------------------------------------------------
   logic     gate_ss;  // Write gate of start and speed settings.
   css_cfg_t act;      // Active settings.
   assign gate_ss = (USER_GROUP_I == CSS_GROUP_ALL) || opt_s;
   css_cfg_reg #(.W(1), .INIT(1'b0)) u_start (
      .clk_i(CLK_SYS_I), .arst_n_i(ARST_N_I), .load_i(load_q),
      .we_i(SET_WE_I[0] && gate_ss), .wdata_i(SET_DATA_I.start_source_select),
      .stored_o(STORED_O.start_source_select), .active_o(act.start_source_select));
   css_cfg_reg #(.W(2), .INIT(CSS_SPD_COMM)) u_speed (
      .clk_i(CLK_SYS_I), .arst_n_i(ARST_N_I), .load_i(load_q),
      .we_i(SET_WE_I[0] && gate_ss), .wdata_i(SET_DATA_I.speed_source_select),
      .stored_o(STORED_O.speed_source_select), .active_o(act.speed_source_select));
   css_cfg_reg #(.W(14), .INIT(CSS_AUTO)) u_net (
      .clk_i(CLK_SYS_I), .arst_n_i(ARST_N_I), .load_i(load_q),
      .we_i(SET_WE_I[1]), .wdata_i(SET_DATA_I.network_source_select),
      .stored_o(STORED_O.network_source_select), .active_o(act.network_source_select));
   css_cfg_reg #(.W(14), .INIT(CSS_AUTO)) u_loc (
      .clk_i(CLK_SYS_I), .arst_n_i(ARST_N_I), .load_i(load_q),
      .we_i(SET_WE_I[2]), .wdata_i(SET_DATA_I.local_source_select),
      .stored_o(STORED_O.local_source_select), .active_o(act.local_source_select));
   css_cfg_reg #(.W(4), .INIT(4'h0)) u_opm (
      .clk_i(CLK_SYS_I), .arst_n_i(ARST_N_I), .load_i(load_q),
      .we_i(SET_OPM_WE_I && gate_ss), .wdata_i(SET_DATA_I.operation_mode_select),
      .stored_o(STORED_O.operation_mode_select), .active_o(act.operation_mode_select));
   // ---------------------------------------------------------------
   // Authority resolution.
   // ---------------------------------------------------------------
   logic [CSS_IF_N-1:0] net_auth;   // Owner in network mode.
   logic [CSS_IF_N-1:0] loc_auth;   // Owner in local unit mode.
   logic                net_ok;     // Network mode may be entered.
   // Network owner from the network source setting.
   always_comb
   begin
      net_auth = '0;
      if (act.network_source_select == CSS_SRC_OPT)
         net_auth[CSS_IF_OPT] = 1'b1;
      else if (act.network_source_select == CSS_SRC_PANEL)
         net_auth[CSS_IF_SER] = 1'b1;
      else if (opt_s)
         net_auth[CSS_IF_OPT] = 1'b1;
      else
         net_auth[CSS_IF_SER] = 1'b1;
   end
   // Local owner; the serial link is chosen only by explicit setting.
   always_comb
   begin
      loc_auth = '0;
      if (act.local_source_select == CSS_SRC_PANEL)
         loc_auth[CSS_IF_SER] = 1'b1;
      else if (act.local_source_select == CSS_SRC_USB)
         loc_auth[CSS_IF_USB] = 1'b1;
      else if (act.local_source_select == CSS_SRC_OPNL)
         loc_auth[CSS_IF_OPNL] = 1'b1;
      else if (usb_s)
         loc_auth[CSS_IF_USB] = 1'b1;
      else if (unit_s)
         loc_auth[CSS_IF_UNIT] = 1'b1;
      else
         loc_auth[CSS_IF_OPNL] = 1'b1;
   end
   // Setting 2 in local mode serves the serial link alone, not the handheld unit.
   // Network entry needs an option card when it owns network, or when both select the connector.
   assign net_ok = opt_s || !(net_auth[CSS_IF_OPT] ||
      (act.network_source_select == CSS_SRC_PANEL && act.local_source_select == CSS_SRC_PANEL));
   // ---------------------------------------------------------------
   // Operation mode machine.
   // ---------------------------------------------------------------
   css_mode_t mode_q;    // Current mode.
   logic      locked;    // Mode fixed by setting.
   assign locked = (act.operation_mode_select == CSS_OPM_PU) ||
                   (act.operation_mode_select == CSS_OPM_COMB3) ||
                   (act.operation_mode_select == CSS_OPM_COMB4);
   // Mode follows requests; a refused network entry keeps the mode.
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         mode_q <= CSS_MODE_EXT;
      else if (boot_q)
         mode_q <= (act.operation_mode_select == CSS_OPM_PU) ? CSS_MODE_PU : CSS_MODE_EXT;
      else if (!locked)
      begin
         unique case (mode_q)
            CSS_MODE_EXT, CSS_MODE_PU:
            begin
               if (NET_REQ_I && net_ok)
                  mode_q <= CSS_MODE_NET;
               else if (PU_REQ_I)
                  mode_q <= CSS_MODE_PU;
               else if (EXT_REQ_I)
                  mode_q <= CSS_MODE_EXT;
            end
            CSS_MODE_NET:
            begin
               if (PU_REQ_I)
                  mode_q <= CSS_MODE_PU;
               else if (EXT_REQ_I)
                  mode_q <= CSS_MODE_EXT;
            end
            default:
               mode_q <= CSS_MODE_EXT;
         endcase
      end
   end
   // Pulse when a network entry is refused.
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         MODE_REFUSED_O <= 1'b0;
      else
         MODE_REFUSED_O <= NET_REQ_I && (locked || !net_ok || mode_q == CSS_MODE_NET ? !net_ok || locked : 1'b0);
   end
   // ---------------------------------------------------------------
   // Request filtering.
   // ---------------------------------------------------------------
   logic [CSS_IF_N-1:0] auth;     // Current owner.
   logic [CSS_IF_N-1:0] wr_ok;    // Interfaces allowed to write.
   always_comb
   begin
      auth = '0;
      if (mode_q == CSS_MODE_NET)
         auth = net_auth;
      else if (mode_q == CSS_MODE_PU)
         auth = loc_auth;
      wr_ok = auth;
      if (mode_q == CSS_MODE_PU && MODBUS_I)
         wr_ok[CSS_IF_SER] = 1'b0;
   end
   // Grants and rejects; reads always pass.
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         GRANT_O  <= '0;
         REJECT_O <= '0;
      end
      else
      begin
         GRANT_O.wr    <= REQ_I.wr & wr_ok;
         GRANT_O.run   <= REQ_I.run & wr_ok & {CSS_IF_N{!act.start_source_select}};
         GRANT_O.freq  <= REQ_I.freq & wr_ok & {CSS_IF_N{act.speed_source_select != CSS_SPD_ANA}};
         GRANT_O.rd    <= REQ_I.rd;
         REJECT_O.wr   <= REQ_I.wr & ~wr_ok;
         REJECT_O.run  <= REQ_I.run & ~(wr_ok & {CSS_IF_N{!act.start_source_select}});
         REJECT_O.freq <= REQ_I.freq & ~(wr_ok & {CSS_IF_N{act.speed_source_select != CSS_SPD_ANA}});
         REJECT_O.rd   <= '0;
      end
   end
   // Status outputs.
   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         MODE_O        <= CSS_MODE_EXT;
         AUTH_O        <= '0;
         START_TERM_O  <= 1'b0;
         FREQ_ANALOG_O <= 1'b0;
         FREQ_COMM_O   <= 1'b1;
      end
      else
      begin
         MODE_O        <= mode_q;
         AUTH_O        <= auth;
         START_TERM_O  <= act.start_source_select;
         FREQ_ANALOG_O <= act.speed_source_select == CSS_SPD_ANA;
         FREQ_COMM_O   <= act.speed_source_select != CSS_SPD_ANA;
      end
   end
endmodule
`default_nettype wire

// [css_top_sva.sv]
// Checker of the command source selector top ports.
`timescale 1ns/1ps
`default_nettype none
module css_top_sva (
   input wire logic              CLK_SYS_I,      // System clock.
   input wire logic              ARST_N_I,       // Reset, active low.
   input wire logic              MODBUS_I,       // Serial link speaks Modbus-RTU.
   input wire css_pkg::css_req_t REQ_I,          // Interface requests.
   input wire logic [2:0]        MODE_O,         // Operation mode.
   input wire logic [4:0]        AUTH_O,         // Authority owner.
   input wire logic              START_TERM_O,   // Start from terminals.
   input wire logic              FREQ_ANALOG_O,  // Analog frequency.
   input wire logic              FREQ_COMM_O,    // Communication frequency.
   input wire logic              MODE_REFUSED_O, // Network mode entry refused.
   input wire css_pkg::css_req_t GRANT_O,        // Granted requests.
   input wire css_pkg::css_req_t REJECT_O        // Rejected requests.
);
   import css_pkg::*;
   // ----------------------------------------------------------------
   // Properties.
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!ARST_N_I);
   logic [4:0] foreign_run;                      // Start strobes from non-owners.
   assign foreign_run = REQ_I.run & ~AUTH_O;
   property p_rd_served;
      1'b1 |=> GRANT_O.rd == $past(REQ_I.rd) && REJECT_O.rd == '0;
   endproperty
   a_rd_served: assert property (p_rd_served) else $error("read not served");
   property p_answered;
      1'b1 |=> (GRANT_O.run | REJECT_O.run) == $past(REQ_I.run) && (GRANT_O.wr | REJECT_O.wr) == $past(REQ_I.wr);
   endproperty
   a_answered: assert property (p_answered) else $error("request not answered");
   property p_exclusive;
      (GRANT_O.run & REJECT_O.run) == '0 && (GRANT_O.freq & REJECT_O.freq) == '0;
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("grant and reject together");
   property p_non_owner;
      foreign_run != '0 ##1 $stable(AUTH_O) |-> (REJECT_O.run & $past(foreign_run)) == $past(foreign_run);
   endproperty
   a_non_owner: assert property (p_non_owner) else $error("non-owner start granted");
   property p_term_start;
      START_TERM_O && REQ_I.run != '0 |=> GRANT_O.run == '0;
   endproperty
   a_term_start: assert property (p_term_start) else $error("start granted in terminal mode");
   property p_analog_freq;
      FREQ_ANALOG_O && REQ_I.freq != '0 |=> GRANT_O.freq == '0;
   endproperty
   a_analog_freq: assert property (p_analog_freq) else $error("frequency granted in analog mode");
   property p_freq_src;
      FREQ_ANALOG_O != FREQ_COMM_O;
   endproperty
   a_freq_src: assert property (p_freq_src) else $error("frequency sources both or none");
   property p_mode_onehot;
      $onehot(MODE_O);
   endproperty
   a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");
   property p_refusal_holds;
      MODE_REFUSED_O |=> $stable(MODE_O) [*2];
   endproperty
   a_refusal_holds: assert property (p_refusal_holds) else $error("mode changed after refusal");
   // The mode output lags by one cycle, so one edge later it shows the mode that judged the request.
   property p_modbus_pu;
      MODBUS_I && REQ_I.run[CSS_IF_SER] |=> MODE_O != 3'b010 || REJECT_O.run[CSS_IF_SER];
   endproperty
   a_modbus_pu: assert property (p_modbus_pu) else $error("Modbus start taken in local mode");
   c_reject: cover property (REJECT_O.run != '0);
   c_refuse: cover property (MODE_REFUSED_O);
   c_net_run: cover property (MODE_O == 3'b100 && GRANT_O.run != '0);
endmodule
bind css_top css_top_sva i_css_top_sva (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .MODBUS_I(MODBUS_I),
   .REQ_I(REQ_I), .MODE_O(MODE_O), .AUTH_O(AUTH_O), .START_TERM_O(START_TERM_O), .FREQ_ANALOG_O(FREQ_ANALOG_O),
   .FREQ_COMM_O(FREQ_COMM_O), .MODE_REFUSED_O(MODE_REFUSED_O), .GRANT_O(GRANT_O), .REJECT_O(REJECT_O));
`default_nettype wire

// [css_far_model.sv]
// Far-side model that issues interface request strobes.
`timescale 1ns/1ps
`default_nettype none
module css_far_model (
   input  wire logic              clk_i,  // System clock.
   input  wire logic              go_i,   // Issue the held request.
   input  wire css_pkg::css_req_t want_i, // Request to issue.
   output css_pkg::css_req_t      req_o   // Strobes toward the selector.
);
   import css_pkg::*;
   // Each request is a one-cycle strobe launched at a falling edge; idle is all zero.
   always_ff @(negedge clk_i)
   begin
      req_o <= go_i ? want_i : '0;
   end
endmodule
`default_nettype wire

// [tb_css_top.sv]
// Self-checking testbench of the command source selector.
`timescale 1ns/1ps
`default_nettype none
module tb_css_top;
   import css_pkg::*;
   logic clk, arst_n, opt, usb, unit, modbus, nreq, preq, ereq, opm_we, go, term, fana, fcomm, refused;
   logic [7:0]  group;   // User group value.
   logic [2:0]  set_we;  // Setting write strobes.
   logic [2:0]  mode;    // Observed mode.
   logic [4:0]  auth;    // Observed owner.
   logic [4:0]  rd;      // Random read mask.
   css_cfg_t    cfg;     // Setting data driven.
   css_cfg_t    stored;  // Observed stored settings.
   css_req_t    want, req, grant, reject;
   logic [39:0] exp_q[$]; // Expected grant and reject pairs.
   int n_errors, checked, cycles;
   css_top i_css_top (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .OPT_FITTED_I(opt), .USB_CONN_I(usb),
      .UNIT_CONN_I(unit), .USER_GROUP_I(group), .SET_WE_I(set_we), .SET_OPM_WE_I(opm_we), .SET_DATA_I(cfg),
      .NET_REQ_I(nreq), .PU_REQ_I(preq), .EXT_REQ_I(ereq), .MODBUS_I(modbus), .REQ_I(req), .MODE_O(mode),
      .AUTH_O(auth), .START_TERM_O(term), .FREQ_ANALOG_O(fana), .FREQ_COMM_O(fcomm),
      .MODE_REFUSED_O(refused), .GRANT_O(grant), .REJECT_O(reject), .STORED_O(stored));
   css_far_model i_css_far_model (.clk_i(clk), .go_i(go), .want_i(want), .req_o(req));
   // ----------------------------------------------------------------
   // Clock, timeout and result checking.
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic give_verdict;
      $display("checked=%0d n_errors=%0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Stops a hung run; the whole sequence needs far fewer cycles.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   // Takes the oldest expected answer whenever the selector answers.
   always @(posedge clk)
   begin
      #1;
      if ((|{grant, reject}) !== 1'b0) chk({grant, reject}, exp_q.size() > 0 ? exp_q.pop_front() : 40'h0);
   end
   // ----------------------------------------------------------------
   // Drivers, all acting on falling edges.
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic boot;
      tick(1);
      arst_n = 1'b0;
      tick(4);
      arst_n = 1'b1;
      tick(3);
   endtask
   task automatic write_set(input logic [2:0] we);
      set_we = we;
      tick(1);
      set_we = 3'h0;
      tick(1);
   endtask
   // Pulses one mode request and looks at the refusal flag just after the rising edge that samples it.
   task automatic switch_mode(input logic [2:0] kind, input logic refuse);
      {nreq, preq, ereq} = kind;
      @(posedge clk);
      #1 chk(refused, refuse);
      @(negedge clk);
      {nreq, preq, ereq} = 3'h0;
      tick(3);
   endtask
   // Issues a request and notes the grant expected; the rest must be rejected.
   task automatic send(input logic [19:0] r, input logic [19:0] g);
      exp_q.push_back({g, r & ~g});
      want <= css_req_t'(r);
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(3);
   endtask
   function automatic logic [19:0] rq(input logic [4:0] wr, input logic [4:0] run, input logic [4:0] fq);
      return {wr, run, fq, rd};
   endfunction
   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial
   begin
      void'($urandom(69966));
      {arst_n, opt, usb, unit, modbus, nreq, preq, ereq, opm_we, go, group, set_we} = '0;
      {n_errors, checked, cycles} = '0;
      cfg = {1'b0, CSS_SPD_COMM, CSS_AUTO, CSS_AUTO, 4'h0};
      want = '0;
      rd = 5'($urandom);
      boot();
      chk(stored, {1'b0, 2'h0, CSS_AUTO, CSS_AUTO, 4'h0});
      chk({mode, term, fana, fcomm}, 6'b001_001);
      switch_mode(3'b010, 1'b0);
      chk({mode, auth}, {3'b010, 5'h01});
      send(rq(5'h00, 5'b01011, 5'h00), rq(5'h00, 5'b00001, 5'h00));
      for (int k = 0; k < 2; k++)
      begin
         usb = (k == 0);
         unit = 1'b1;
         boot();
         switch_mode(3'b010, 1'b0);
         chk(auth, (k == 0) ? 5'h02 : 5'h04);
      end
      {usb, unit} = 2'b00;
      for (int k = 0; k < 2; k++)
      begin
         cfg.local_source_select = (k == 0) ? CSS_SRC_USB : CSS_SRC_OPNL;
         write_set(3'b100);
         chk(stored, cfg);
         boot();
         switch_mode(3'b010, 1'b0);
         chk(auth, (k == 0) ? 5'h02 : 5'h01);
      end
      group = 8'h05;
      cfg = {1'b1, CSS_SPD_ANA, CSS_SRC_OPT, CSS_AUTO, 4'h0};
      write_set(3'b111);
      chk(stored, {1'b0, 2'h0, CSS_SRC_OPT, CSS_AUTO, 4'h0});
      opt = 1'b1;
      tick(3);
      write_set(3'b001);
      chk({stored, term}, {cfg, 1'b0});
      boot();
      chk({term, fana, fcomm}, 3'b110);
      switch_mode(3'b100, 1'b0);
      chk({mode, auth}, {3'b100, 5'h10});
      rd = 5'($urandom);
      send(rq(5'b11000, 5'b10000, 5'b10000), rq(5'b10000, 5'h00, 5'h00));
      cfg.start_source_select = 1'b0;
      cfg.speed_source_select = CSS_SPD_MIX;
      write_set(3'b001);
      boot();
      chk({term, fana, fcomm}, 3'b001);
      switch_mode(3'b100, 1'b0);
      send(rq(5'h00, 5'b10000, 5'b10000), rq(5'h00, 5'b10000, 5'b10000));
      opt = 1'b0;
      boot();
      switch_mode(3'b100, 1'b1);
      chk(mode, 3'b001);
      cfg.network_source_select = CSS_AUTO;
      write_set(3'b010);
      for (int k = 0; k < 2; k++)
      begin
         opt = (k == 1);
         boot();
         switch_mode(3'b100, 1'b0);
         chk(auth, (k == 1) ? 5'h10 : 5'h08);
         send(rq(5'h00, 5'b01000, 5'h00), rq(5'h00, (k == 1) ? 5'h00 : 5'b01000, 5'h00));
      end
      opt = 1'b0;
      cfg.network_source_select = CSS_SRC_PANEL;
      cfg.local_source_select = CSS_SRC_PANEL;
      write_set(3'b110);
      boot();
      switch_mode(3'b100, 1'b1);
      chk(mode, 3'b001);
      switch_mode(3'b010, 1'b0);
      modbus = 1'b1;
      send(rq(5'h00, 5'b01000, 5'h00), rq(5'h00, 5'h00, 5'h00));
      modbus = 1'b0;
      send(rq(5'h00, 5'b01000, 5'h00), rq(5'h00, 5'b01000, 5'h00));
      switch_mode(3'b001, 1'b0);
      chk(mode, 3'b001);
      group = 8'h00;
      cfg.operation_mode_select = CSS_OPM_PU;
      opm_we = 1'b1;
      tick(1);
      opm_we = 1'b0;
      tick(1);
      chk(stored.operation_mode_select, CSS_OPM_PU);
      boot();
      chk(mode, 3'b010);
      switch_mode(3'b001, 1'b0);
      chk(mode, 3'b010);
      chk(32'(exp_q.size()), 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
